/* src/slcd_params.svh */
`ifndef SLCD_PARAMS_SVH
`define SLCD_PARAMS_SVH

// Strap bus width and its value when no strap is terminated.
`define SLCD_STRAP_W 18
`define SLCD_STRAP_DEFAULT 18'h3ffff

// Strap field positions.
`define SLCD_BIT_LANE_ORDER 2
`define SLCD_BIT_SPLIT_LO 5
`define SLCD_BIT_SPLIT_HI 6

// Lane counts.
`define SLCD_GFX_LANES 16
`define SLCD_EXTRA_LANES 4

// Synchroniser bundle: {extra rx, graphics rx, twenty-lane, platform reset_n, term, strap}.
`define SLCD_SYNC_W 58
`define SLCD_SYNC_RST 58'h0000000_0003ffff
`define SLCD_POS_TERM 18
`define SLCD_POS_PRST 36
`define SLCD_POS_TWENTY 37
`define SLCD_POS_GFX_RX 38
`define SLCD_POS_EXTRA_RX 54

// Reset values of the decoded outputs and the shared memory reset.
`define SLCD_TX_RST 16'h0000
`define SLCD_EXTRA_RST 4'h0
`define SLCD_REV_RST 1'b0
`define SLCD_SPLIT_RST 2'b11
`define SLCD_RSVD_RST 1'b0
`define SLCD_EXTRA_EN_RST 1'b0
`define SLCD_TWENTY_RST 1'b0
`define SLCD_MEM_RST_N_RST 1'b0

`endif

/* src/slcd_pkg.sv */
package slcd_pkg;

	// Lane split encodings carried by the two split strap bits.
	typedef enum logic [1:0] {
		SPLIT_X8_2X4 = 2'b00,
		SPLIT_RSVD = 2'b01,
		SPLIT_2X8 = 2'b10,
		SPLIT_X16 = 2'b11
	} slcd_split_t;

	// Decoder phases: sampling under platform reset, holding afterwards.
	typedef enum logic [0:0] {
		ST_SAMPLE = 1'b0,
		ST_HOLD = 1'b1
	} slcd_state_t;

endpackage

/* src/slcd_sync_if.sv */
`timescale 1ns/1ps
`include "slcd_params.svh"

// Carries raw pin levels into the synchroniser and the settled copies back.
interface slcd_sync_if;
	logic [`SLCD_SYNC_W-1:0] raw;
	logic [`SLCD_SYNC_W-1:0] synced;

	modport sync_mp (input raw, output synced);
	modport user_mp (output raw, input synced);
endinterface

/* src/slcd_sync.sv */
`timescale 1ns/1ps
`include "slcd_params.svh"

module slcd_sync (
	input wire logic i_sys_clk, // System clock.
	input wire logic i_rst, // Synchronous reset, active high.
	slcd_sync_if.sync_mp sif // Raw pins in, settled levels out.
);
	logic [`SLCD_SYNC_W-1:0] meta_ff;
	logic [`SLCD_SYNC_W-1:0] sync_ff;

	// First stage; only the second stage reads it.
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			meta_ff <= `SLCD_SYNC_RST;
		end else begin
			meta_ff <= sif.raw;
		end
	end

	// Second stage feeds all logic.
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			sync_ff <= `SLCD_SYNC_RST;
		end else begin
			sync_ff <= meta_ff;
		end
	end

	assign sif.synced = sync_ff;
endmodule

/* src/slcd_top.sv */
`timescale 1ns/1ps
`include "slcd_params.svh"

//
// Functional notes
// - An unterminated strap pin reads as one, selecting its default.
// - Strap bit two: one keeps lane order, zero reverses sixteen graphics lanes.
// - Strap bits six:five: 00 x8+2x4, 10 2x8, 11 x16, 01 reserved.
// - Strap bits 1:0, 3, 4 and 17:7 never change any decoded setting.
// - One memory device reset output, shared by all memory channels.
// - The four extra lanes work only on twenty-lane platforms.
//
module slcd_top
	import slcd_pkg::*;
(
	input wire logic i_sys_clk, // System clock, 25 MHz.
	input wire logic i_rst, // Synchronous reset, active high.
	input wire logic i_platform_reset_n, // Platform reset pin, active low.
	input wire logic [`SLCD_STRAP_W-1:0] i_strap, // Board strap levels.
	input wire logic [`SLCD_STRAP_W-1:0] i_strap_term, // High where the board terminates a strap.
	input wire logic i_twenty_lane_platform, // High on a twenty-lane platform.
	input wire logic [`SLCD_GFX_LANES-1:0] i_graphics_tx_data, // Core lane data to send.
	output logic [`SLCD_GFX_LANES-1:0] o_graphics_lane_tx, // Graphics lane pins.
	input wire logic [`SLCD_GFX_LANES-1:0] i_graphics_lane_rx, // Graphics lane pins.
	output logic [`SLCD_GFX_LANES-1:0] o_graphics_rx_data, // Received data in core order.
	input wire logic [`SLCD_EXTRA_LANES-1:0] i_extra_tx_data, // Core data for extra lanes.
	output logic [`SLCD_EXTRA_LANES-1:0] o_extra_lane_tx, // Extra lane pins.
	input wire logic [`SLCD_EXTRA_LANES-1:0] i_extra_lane_rx, // Extra lane pins.
	output logic [`SLCD_EXTRA_LANES-1:0] o_extra_rx_data, // Received extra lane data.
	output logic o_lane_reversed, // High when lane numbers are reversed.
	output logic [1:0] o_lane_split, // Decoded lane split code.
	output logic o_split_reserved, // High when the reserved split code is strapped.
	output logic o_extra_lane_en, // High when the extra lanes are in use.
	output logic o_config_valid, // High once settings are held.
	output logic o_memory_device_reset_n // Shared memory reset, active low.
);

	// ****************************************
	// Helpers
	// ****************************************

	// Mirrors the sixteen graphics lanes, lane i to lane 15-i.
	function automatic logic [`SLCD_GFX_LANES-1:0] slcd_rev16(
		input logic [`SLCD_GFX_LANES-1:0] v
	);
		logic [`SLCD_GFX_LANES-1:0] r;
		r = '0;
		for (int i = 0; i < `SLCD_GFX_LANES; i++) begin
			r[i] = v[`SLCD_GFX_LANES-1-i];
		end
		return r;
	endfunction

	// ****************************************
	// Pin synchronisation
	// ****************************************

	slcd_sync_if sif ();

	// All pin inputs travel through the two-stage synchroniser.
	assign sif.raw = {i_extra_lane_rx, i_graphics_lane_rx, i_twenty_lane_platform,
		i_platform_reset_n, i_strap_term, i_strap};

	slcd_sync u_sync (
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.sif(sif)
	);

	logic [`SLCD_STRAP_W-1:0] strap_s;
	logic [`SLCD_STRAP_W-1:0] term_s;
	logic [`SLCD_STRAP_W-1:0] eff_strap;
	logic plat_asserted;
	logic twenty_s;
	logic [`SLCD_GFX_LANES-1:0] gfx_rx_s;
	logic [`SLCD_EXTRA_LANES-1:0] extra_rx_s;

	// Unpacks the settled bundle.
	assign strap_s = sif.synced[`SLCD_STRAP_W-1:0];
	assign term_s = sif.synced[`SLCD_POS_PRST-1:`SLCD_POS_TERM];
	assign plat_asserted = ~sif.synced[`SLCD_POS_PRST];
	assign twenty_s = sif.synced[`SLCD_POS_TWENTY];
	assign gfx_rx_s = sif.synced[`SLCD_POS_EXTRA_RX-1:`SLCD_POS_GFX_RX];
	assign extra_rx_s = sif.synced[`SLCD_SYNC_W-1:`SLCD_POS_EXTRA_RX];

	// An open strap floats to one.
	assign eff_strap = strap_s | ~term_s;

	// ****************************************
	// Sample and hold control
	// ****************************************

	slcd_state_t state_ff;
	slcd_state_t nxt_state;

	// Sampling follows the platform reset level.
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			ST_SAMPLE: begin
				nxt_state = plat_asserted ? ST_SAMPLE : ST_HOLD;
			end
			ST_HOLD: begin
				nxt_state = plat_asserted ? ST_SAMPLE : ST_HOLD;
			end
		endcase
	end

	// State register.
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			state_ff <= ST_SAMPLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	logic [`SLCD_STRAP_W-1:0] strap_ff;
	logic twenty_ff;

	// Straps are captured only while platform reset is asserted.
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			strap_ff <= `SLCD_STRAP_DEFAULT;
			twenty_ff <= `SLCD_TWENTY_RST;
		end else if (plat_asserted) begin
			strap_ff <= eff_strap;
			twenty_ff <= twenty_s;
		end
	end

	// ****************************************
	// Decoded settings
	// ****************************************

	logic reversed_ff;
	logic [1:0] split_ff;
	logic split_rsvd_ff;
	logic extra_en_ff;

	// Only the order bit and the split pair are decoded; all other straps are ignored.
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			reversed_ff <= `SLCD_REV_RST;
			split_ff <= `SLCD_SPLIT_RST;
			split_rsvd_ff <= `SLCD_RSVD_RST;
			extra_en_ff <= `SLCD_EXTRA_EN_RST;
		end else begin
			reversed_ff <= ~strap_ff[`SLCD_BIT_LANE_ORDER];
			split_ff <= strap_ff[`SLCD_BIT_SPLIT_HI:`SLCD_BIT_SPLIT_LO];
			split_rsvd_ff <= (strap_ff[`SLCD_BIT_SPLIT_HI:`SLCD_BIT_SPLIT_LO] == SPLIT_RSVD);
			extra_en_ff <= twenty_ff;
		end
	end

	assign o_lane_reversed = reversed_ff;
	assign o_lane_split = split_ff;
	assign o_split_reserved = split_rsvd_ff;
	assign o_extra_lane_en = extra_en_ff;
	assign o_config_valid = (state_ff == ST_HOLD);

	// ****************************************
	// Lane data paths
	// ****************************************

	logic [`SLCD_GFX_LANES-1:0] gfx_tx_ff;
	logic [`SLCD_GFX_LANES-1:0] gfx_rx_ff;

	// Graphics lanes, mirrored in both directions when reversal is strapped.
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			gfx_tx_ff <= `SLCD_TX_RST;
			gfx_rx_ff <= `SLCD_TX_RST;
		end else begin
			gfx_tx_ff <= reversed_ff ? slcd_rev16(i_graphics_tx_data) : i_graphics_tx_data;
			gfx_rx_ff <= reversed_ff ? slcd_rev16(gfx_rx_s) : gfx_rx_s;
		end
	end

	logic [`SLCD_EXTRA_LANES-1:0] extra_tx_ff;
	logic [`SLCD_EXTRA_LANES-1:0] extra_rx_ff;

	// Extra lanes stay idle unless the platform carries twenty lanes.
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			extra_tx_ff <= `SLCD_EXTRA_RST;
			extra_rx_ff <= `SLCD_EXTRA_RST;
		end else begin
			extra_tx_ff <= extra_en_ff ? i_extra_tx_data : `SLCD_EXTRA_RST;
			extra_rx_ff <= extra_en_ff ? extra_rx_s : `SLCD_EXTRA_RST;
		end
	end

	assign o_graphics_lane_tx = gfx_tx_ff;
	assign o_graphics_rx_data = gfx_rx_ff;
	assign o_extra_lane_tx = extra_tx_ff;
	assign o_extra_rx_data = extra_rx_ff;

	// ****************************************
	// Shared memory reset
	// ****************************************

	logic mem_rst_n_ff;

	// One reset line for all memory channels, low while platform reset is asserted.
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			mem_rst_n_ff <= `SLCD_MEM_RST_N_RST;
		end else begin
			mem_rst_n_ff <= ~plat_asserted;
		end
	end

	assign o_memory_device_reset_n = mem_rst_n_ff;

	// ****************************************
	// Assertions
	// ****************************************

	// Open straps are captured as ones.
	a_open_strap_ones: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(plat_asserted && term_s == '0) |=> strap_ff == `SLCD_STRAP_DEFAULT)
		else $error("Open straps not captured as ones.");

	// Reversed order mirrors the transmit lanes.
	a_lane_mirror: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		reversed_ff |=> o_graphics_lane_tx == slcd_rev16($past(i_graphics_tx_data)))
		else $error("Reversed lanes not mirrored.");

	// Normal order passes lanes straight through.
	a_lane_straight: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		!reversed_ff |=> o_graphics_lane_tx == $past(i_graphics_tx_data))
		else $error("Normal lane order altered.");

	// Split output follows the split strap pair.
	a_split_decode: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		1'b1 |=> (o_lane_split == $past(strap_ff[6:5]))
			&& (o_split_reserved == ($past(strap_ff[6:5]) == 2'b01)))
		else $error("Lane split decoded wrongly.");

	// Lane split and lane order change only when their own strap bits change.
	a_reserved_ignored: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		($stable(strap_ff[6:5]) && $stable(strap_ff[2])) |=>
			($stable(o_lane_split) && $stable(o_lane_reversed)))
		else $error("Reserved strap altered a setting.");

	// Memory reset is low one cycle after platform reset is seen.
	a_mem_reset_low: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		plat_asserted |=> !o_memory_device_reset_n)
		else $error("Memory reset not asserted.");

	// Extra lanes stay idle when not enabled.
	a_extra_idle: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		!o_extra_lane_en |=> (o_extra_lane_tx == 4'h0 && o_extra_rx_data == 4'h0))
		else $error("Extra lanes active without support.");

	// Captured straps hold once platform reset is released.
	a_hold_stable: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		!plat_asserted |=> strap_ff == $past(strap_ff))
		else $error("Straps changed outside platform reset.");

	// Straps track the pins while platform reset is asserted.
	a_sample_track: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		plat_asserted |=> strap_ff == $past(eff_strap))
		else $error("Straps not sampled during platform reset.");

endmodule

/* bench/slcd_board_model.sv */
`timescale 1ns/1ps
`include "slcd_params.svh"

// ****************************************
// Board straps and companion hub
// ****************************************
module slcd_board_model (
	input wire logic i_sys_clk, // System clock.
	input wire logic i_hub_reset, // High while the hub holds platform reset.
	input wire logic [`SLCD_STRAP_W-1:0] i_strap_val, // Levels on terminated pins.
	input wire logic [`SLCD_STRAP_W-1:0] i_term_val, // High where a pin is terminated.
	input wire logic i_twenty, // Twenty-lane platform level.
	output logic o_platform_reset_n, // Platform reset, active low.
	output logic [`SLCD_STRAP_W-1:0] o_strap, // Strap pin levels.
	output logic [`SLCD_STRAP_W-1:0] o_strap_term, // Termination map.
	output logic o_twenty_lane_platform // Twenty-lane platform pin.
);
	logic [`SLCD_STRAP_W-1:0] float_ff;

	// Pins start in reset with every strap terminated high.
	initial begin
		float_ff = 18'h2aaaa;
		o_platform_reset_n = 1'b0;
		o_strap = 18'h3ffff;
		o_strap_term = 18'h3ffff;
		o_twenty_lane_platform = 1'b0;
	end

	// Open pins wander every cycle, so only the termination map can give them a value.
	always @(negedge i_sys_clk) begin
		float_ff <= ~float_ff;
		o_platform_reset_n <= ~i_hub_reset;
		o_strap <= (i_strap_val & i_term_val) | (float_ff & ~i_term_val);
		o_strap_term <= i_term_val;
		o_twenty_lane_platform <= i_twenty;
	end
endmodule

/* bench/tb.sv */
`timescale 1ns/1ps
`include "slcd_params.svh"

module tb;
	import slcd_pkg::*;
	logic i_sys_clk = 1'b0;
	logic i_rst = 1'b1;
	logic hub_reset = 1'b1;
	logic [17:0] strap_val = 18'h3ffff;
	logic [17:0] term_val = 18'h3ffff;
	logic twenty = 1'b0;
	logic [15:0] gtx = 16'h0000;
	logic [15:0] grx = 16'h0000;
	logic [3:0] etx = 4'h0;
	logic [3:0] erx = 4'h0;
	logic platform_reset_n;
	logic twenty_pin;
	logic [17:0] strap_pin;
	logic [17:0] term_pin;
	logic [15:0] lane_tx;
	logic [15:0] rx_data;
	logic [3:0] e_lane_tx;
	logic [3:0] e_rx_data;
	logic reversed;
	logic split_rsvd;
	logic extra_en;
	logic cfg_valid;
	logic mem_rst_n;
	logic [1:0] split;
	int failures = 0;
	int cmp_count = 0;

	// ****************************************
	// Clock, model and design
	// ****************************************
	// A 25 MHz clock.
	always #20 i_sys_clk = ~i_sys_clk;

	slcd_board_model u_board (.i_sys_clk(i_sys_clk), .i_hub_reset(hub_reset),
		.i_strap_val(strap_val), .i_term_val(term_val), .i_twenty(twenty),
		.o_platform_reset_n(platform_reset_n), .o_strap(strap_pin),
		.o_strap_term(term_pin), .o_twenty_lane_platform(twenty_pin));

	slcd_top u_dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
		.i_platform_reset_n(platform_reset_n), .i_strap(strap_pin),
		.i_strap_term(term_pin), .i_twenty_lane_platform(twenty_pin),
		.i_graphics_tx_data(gtx), .o_graphics_lane_tx(lane_tx),
		.i_graphics_lane_rx(grx), .o_graphics_rx_data(rx_data),
		.i_extra_tx_data(etx), .o_extra_lane_tx(e_lane_tx),
		.i_extra_lane_rx(erx), .o_extra_rx_data(e_rx_data),
		.o_lane_reversed(reversed), .o_lane_split(split),
		.o_split_reserved(split_rsvd), .o_extra_lane_en(extra_en),
		.o_config_valid(cfg_valid), .o_memory_device_reset_n(mem_rst_n));

	// ****************************************
	// Access and compare tasks
	// ****************************************
	// Lane i of the core side lands on lane 15-i of the pins when reversed.
	function automatic logic [15:0] rev16(input logic [15:0] v);
		for (int k = 0; k < 16; k++) begin
			rev16[k] = v[15-k];
		end
	endfunction

	task automatic chk_bit(input string name, input logic exp, input logic got);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %s: expected %b, seen %b", name, exp, got);
		end
	endtask

	task automatic chk_vec(input string name, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask

	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Holds platform reset and presents new straps long enough to reach the outputs.
	task automatic strap_cycle(input logic [17:0] s, input logic [17:0] t, input logic tw);
		hub_reset <= 1'b1;
		strap_val <= s;
		term_val <= t;
		twenty <= tw;
		repeat (9) @(negedge i_sys_clk);
	endtask

	// Releases platform reset and waits, bounded, for the settings to be held.
	task automatic release_hub();
		int n;
		n = 0;
		hub_reset <= 1'b0;
		while (cfg_valid !== 1'b1 && n < 20) begin
			@(negedge i_sys_clk);
			n++;
		end
		if (cfg_valid !== 1'b1) begin
			failures++;
			final_report();
		end
	endtask

	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		logic [17:0] s;
		repeat (6) @(negedge i_sys_clk);
		i_rst <= 1'b0;
		strap_cycle(18'h00000, 18'h00000, 1'b0);
		chk_bit("reversed", 1'b0, reversed);
		chk_vec("split", 16'h0003, {14'h0000, split});
		chk_bit("valid", 1'b0, cfg_valid);
		chk_bit("memory reset", 1'b0, mem_rst_n);
		// Both lane orders and all four split codes, with the reserved pins set high in the four runs where i[0] differs from i[2].
		for (int i = 0; i < 8; i++) begin
			s = {11'h000, i[1:0], 2'b00, i[2], 2'b00};
			s = s | ((i[0] ^ i[2]) ? 18'h3ff9b : 18'h00000);
			strap_cycle(s, 18'h3ffff, i[1]);
			chk_bit("reversed", ~i[2], reversed);
			chk_vec("split", {14'h0000, i[1:0]}, {14'h0000, split});
			chk_bit("split reserved", i[1:0] == 2'b01, split_rsvd);
			chk_bit("extra enable", i[1], extra_en);
			release_hub();
			chk_bit("memory reset", 1'b1, mem_rst_n);
			gtx <= 16'h8c31 ^ {i[3:0], i[3:0], 8'h00};
			grx <= 16'h5e07 ^ {8'h00, i[3:0], i[3:0]};
			etx <= 4'h9 ^ i[3:0];
			erx <= 4'h6;
			repeat (5) @(negedge i_sys_clk);
			chk_vec("graphics tx", i[2] ? gtx : rev16(gtx), lane_tx);
			chk_vec("graphics rx", i[2] ? grx : rev16(grx), rx_data);
			chk_vec("extra tx", i[1] ? {12'h000, etx} : 16'h0000, {12'h000, e_lane_tx});
			chk_vec("extra rx", i[1] ? 16'h0006 : 16'h0000, {12'h000, e_rx_data});
		end
		// Straps moved after release must not reach the held settings.
		strap_val <= 18'h00000;
		twenty <= 1'b0;
		repeat (8) @(negedge i_sys_clk);
		chk_bit("held reversed", 1'b0, reversed);
		chk_vec("held split", 16'h0003, {14'h0000, split});
		chk_bit("held extra enable", 1'b1, extra_en);
		// A second platform reset picks up the new straps and drops memory reset.
		strap_cycle(18'h00000, 18'h3ffff, 1'b0);
		chk_bit("resampled reversed", 1'b1, reversed);
		chk_bit("valid again", 1'b0, cfg_valid);
		chk_bit("memory reset again", 1'b0, mem_rst_n);
		final_report();
	end
endmodule
